// *** rtl/two_wire_map.svh ***
// offsets, field positions, reset values, status codes and timing counts of the two-wire port
`ifndef TWO_WIRE_MAP_SVH
`define TWO_WIRE_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CTRL_ADDR          2'h0
`define DATA_ADDR          2'h1
`define STATUS_ADDR        2'h2

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define CTRL_FLAG_BIT      7
`define CTRL_ACK_EN_BIT    6
`define CTRL_START_BIT     5
`define CTRL_STOP_BIT      4
`define CTRL_WCOL_BIT      3
`define CTRL_ENABLE_BIT    2
`define CTRL_INT_EN_BIT    0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DATA_RESET         8'hff
`define PRESCALE_RESET     2'h0

// ----------------------------------------------------------------
// status codes, prescaler bits zero
// ----------------------------------------------------------------
`define ST_START_SENT      8'h08
`define ST_REP_START_SENT  8'h10
`define ST_ADDR_W_ACK      8'h18
`define ST_ADDR_W_NACK     8'h20
`define ST_DATA_TX_ACK     8'h28
`define ST_DATA_TX_NACK    8'h30
`define ST_ARB_LOST        8'h38
`define ST_ADDR_R_ACK      8'h40
`define ST_ADDR_R_NACK     8'h48
`define ST_DATA_RX_ACK     8'h50
`define ST_DATA_RX_NACK    8'h58
`define ST_NO_INFO         8'hf8
`define STATUS_MASK        8'hf8

// ----------------------------------------------------------------
// timing: a quarter of a bit period
// ----------------------------------------------------------------
`define CLK_MHZ            100
`define QUARTER_NS         2500
`define QUARTER_CYCLES     ((`QUARTER_NS * `CLK_MHZ) / 1000)

`endif

// *** rtl/two_wire_pkg.sv ***
// types shared by the two-wire port modules
package two_wire_pkg;

   typedef enum logic [3:0] {
      seq_idle        = 4'h0,
      seq_wait_free   = 4'h1,
      seq_start_hold  = 4'h2,
      seq_hold        = 4'h3,
      seq_bit_low     = 4'h4,
      seq_bit_rise    = 4'h5,
      seq_bit_fall    = 4'h6,
      seq_stop_low    = 4'h7,
      seq_stop_rise   = 4'h8,
      seq_stop_end    = 4'h9,
      seq_rep_release = 4'ha,
      seq_rep_rise    = 4'hb
   } seq_state_t;

   typedef struct packed {
      logic       flag;
      logic       acknowledge_enable;
      logic       start_request;
      logic       stop_request;
      logic       write_collision;
      logic       enable;
      logic       interrupt_enable;
   } control_t;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       write;
      logic       read;
   } bus_req_t;

   typedef struct packed {
      logic       scl_oe;
      logic       sda_oe;
   } line_drive_t;

   typedef struct packed {
      seq_state_t  seq;
      control_t    ctrl;
      logic [7:0]  shift_data;
      logic [7:0]  shift;
      logic [3:0]  bit_idx;
      logic [7:0]  status_code;
      logic [1:0]  prescale;
      logic        sampled;
      logic        addr_phase;
      logic        is_read;
      logic        own_bus;
      logic        busy;
      logic        scl_prev;
      logic        sda_prev;
      line_drive_t drive;
      logic        drive_level;
      logic [7:0]  rdata;
   } core_state_t;

endpackage

// *** rtl/pin_sync.sv ***
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic raw_in,
   output var  logic clean_out
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic clean;
   } sync_state_t;

   sync_state_t cur;
   sync_state_t next_cur;

   // ----------------------------------------------------------------
   // first stage feeds only the second
   // ----------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.s1 = raw_in;
      next_cur.s2 = cur.s1;
      next_cur.s3 = cur.s2;
      if (cur.s2 == cur.s3) begin
         next_cur.clean = cur.s3;
      end
   end

   // idle bus level is high, so reset to one
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cur <= '1;
      end else begin
         cur <= next_cur;
      end
   end

   assign clean_out = cur.clean;

endmodule // pin_sync

`default_nettype wire

// *** rtl/bit_timer.sv ***
// quarter-bit enable pulse divider
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module bit_timer (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic run_in,
   output var  logic tick_out
);

   typedef struct packed {
      logic [8:0] count;
      logic       tick;
   } timer_state_t;

   timer_state_t cur;
   timer_state_t next_cur;

   always_comb begin
      next_cur = cur;
      next_cur.tick = 1'b0;
      if (!run_in) begin
         next_cur.count = 9'h000;
      end else if (cur.count == 9'(`QUARTER_CYCLES - 1)) begin
         next_cur.count = 9'h000;
         next_cur.tick = 1'b1;
      end else begin
         next_cur.count = cur.count + 9'h001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign tick_out = cur.tick;

endmodule // bit_timer

`default_nettype wire

// *** rtl/two_wire_master_transmitter.sv ***
// two-wire port master sequencer with control, data and status registers
// What this block does
// - master transmit and receive roles; slave roles report no-info status only
// - read bit and not-acknowledge are high on data line; bytes eight bits
// - while flag is set after a start or a byte the bus is held, scl low, nothing moves
// - start first; address lsb selects master transmit or master receive
// - start is generated only once the bus is seen free
// - after start sent, flag set with status 08
// - writing one to flag clears it; zero leaves it
// - bus activity only while enable is set
// - after address with write: status 18, 20 or 38
// - data write while flag low is dropped and sets write collision
// - after each data byte and its acknowledge, flag set with status
// - stop bit clears itself after stop; start set follows with a start
// - arbitration lost: bus released at once; clear goes idle, or start again when free
// - repeated start gives status 10 and allows any new address
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_map.svh"

module two_wire_master_transmitter (
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   input  wire two_wire_pkg::bus_req_t reg_req_in,
   output var  logic [7:0]             rdata_out,
   input  wire logic                   scl_in,
   output var  logic                   scl_out,
   output var  logic                   scl_oe_out,
   input  wire logic                   sda_in,
   output var  logic                   sda_out,
   output var  logic                   sda_oe_out
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] status_for(input logic addr_phase,
                                             input logic is_read,
                                             input logic nack);
      logic [7:0] code;
      code = `ST_NO_INFO;
      if (addr_phase && !is_read) begin
         code = nack ? `ST_ADDR_W_NACK : `ST_ADDR_W_ACK;
      end else if (addr_phase) begin
         code = nack ? `ST_ADDR_R_NACK : `ST_ADDR_R_ACK;
      end else if (!is_read) begin
         code = nack ? `ST_DATA_TX_NACK : `ST_DATA_TX_ACK;
      end else begin
         code = nack ? `ST_DATA_RX_NACK : `ST_DATA_RX_ACK;
      end
      return code;
   endfunction

   // open drain: a one is sent by releasing, so drive only for zero
   function automatic logic drive_low(input logic [3:0] bit_idx,
                                      input logic [7:0] shift,
                                      input logic       receiving,
                                      input logic       ack_en);
      logic low;
      low = 1'b0;
      if (bit_idx < 4'h8) begin
         low = ~shift[7];
      end else if (receiving) begin
         low = ack_en;
      end
      return low;
   endfunction

   // ----------------------------------------------------------------
   // pin sampling and bit timing
   // ----------------------------------------------------------------
   logic                      scl_clean;
   logic                      sda_clean;
   logic                      tick;
   two_wire_pkg::core_state_t cur;
   two_wire_pkg::core_state_t next_cur;

   pin_sync scl_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .raw_in    (scl_in),
      .clean_out (scl_clean)
   );

   pin_sync sda_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .raw_in    (sda_in),
      .clean_out (sda_clean)
   );

   bit_timer quarter_timer (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .run_in   (cur.ctrl.enable),
      .tick_out (tick)
   );

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic start_seen;
      logic stop_seen;
      logic hw_set;
      logic flag_clear;
      logic receiving;
      logic lost;
      logic ctrl_wr;
      start_seen = 1'b0;
      stop_seen = 1'b0;
      hw_set = 1'b0;
      flag_clear = 1'b0;
      receiving = 1'b0;
      lost = 1'b0;
      ctrl_wr = 1'b0;
      next_cur = cur;

      // bus monitor, also watching other masters
      next_cur.scl_prev = scl_clean;
      next_cur.sda_prev = sda_clean;
      start_seen = cur.scl_prev && scl_clean && cur.sda_prev && !sda_clean;
      stop_seen = cur.scl_prev && scl_clean && !cur.sda_prev && sda_clean;
      if (start_seen) begin
         next_cur.busy = 1'b1;
      end else if (stop_seen) begin
         next_cur.busy = 1'b0;
      end

      // register reads: data stands one cycle after the strobe
      next_cur.rdata = 8'h00;
      if (reg_req_in.read) begin
         unique case (reg_req_in.addr)
            `CTRL_ADDR: begin
               next_cur.rdata = {cur.ctrl.flag, cur.ctrl.acknowledge_enable,
                                 cur.ctrl.start_request, cur.ctrl.stop_request,
                                 cur.ctrl.write_collision, cur.ctrl.enable,
                                 1'b0, cur.ctrl.interrupt_enable};
            end
            `DATA_ADDR: begin
               next_cur.rdata = cur.shift_data;
            end
            `STATUS_ADDR: begin
               next_cur.rdata = {cur.status_code[7:3], 1'b0, cur.prescale};
            end
            default: begin
               next_cur.rdata = 8'h00;
            end
         endcase
      end

      // register writes
      ctrl_wr = reg_req_in.write && (reg_req_in.addr == `CTRL_ADDR);
      if (ctrl_wr) begin
         next_cur.ctrl.acknowledge_enable = reg_req_in.wdata[`CTRL_ACK_EN_BIT];
         next_cur.ctrl.start_request = reg_req_in.wdata[`CTRL_START_BIT];
         next_cur.ctrl.stop_request = reg_req_in.wdata[`CTRL_STOP_BIT];
         next_cur.ctrl.enable = reg_req_in.wdata[`CTRL_ENABLE_BIT];
         next_cur.ctrl.interrupt_enable = reg_req_in.wdata[`CTRL_INT_EN_BIT];
         flag_clear = reg_req_in.wdata[`CTRL_FLAG_BIT];
      end
      if (reg_req_in.write && (reg_req_in.addr == `DATA_ADDR)) begin
         if (cur.ctrl.flag) begin
            next_cur.shift_data = reg_req_in.wdata;
            next_cur.ctrl.write_collision = 1'b0;
         end else begin
            next_cur.ctrl.write_collision = 1'b1;
         end
      end
      if (reg_req_in.write && (reg_req_in.addr == `STATUS_ADDR)) begin
         next_cur.prescale = reg_req_in.wdata[1:0];
      end

      receiving = cur.is_read && !cur.addr_phase;

      // ----------------------------------------------------------------
      // bus sequencer
      // ----------------------------------------------------------------
      unique case (cur.seq)
         two_wire_pkg::seq_idle: begin
            if (!cur.ctrl.flag && cur.ctrl.start_request) begin
               next_cur.seq = two_wire_pkg::seq_wait_free;
            end
         end
         two_wire_pkg::seq_wait_free: begin
            // a restart owns the bus already, so busy does not block it
            if (tick && (!cur.busy || cur.own_bus) && scl_clean && sda_clean) begin
               next_cur.drive.sda_oe = 1'b1;
               next_cur.seq = two_wire_pkg::seq_start_hold;
            end
         end
         two_wire_pkg::seq_start_hold: begin
            if (tick) begin
               next_cur.drive.scl_oe = 1'b1;
               next_cur.own_bus = 1'b1;
               next_cur.addr_phase = 1'b1;
               next_cur.status_code = cur.own_bus ? `ST_REP_START_SENT : `ST_START_SENT;
               hw_set = 1'b1;
               next_cur.seq = two_wire_pkg::seq_hold;
            end
         end
         two_wire_pkg::seq_hold: begin
            // after a start or a byte, scl stays low while the flag is up
            if (!cur.ctrl.flag) begin
               if (!cur.own_bus) begin
                  next_cur.seq = cur.ctrl.start_request ? two_wire_pkg::seq_wait_free
                                                        : two_wire_pkg::seq_idle;
               end else if (cur.ctrl.stop_request) begin
                  next_cur.seq = two_wire_pkg::seq_stop_low;
               end else if (cur.ctrl.start_request) begin
                  next_cur.seq = two_wire_pkg::seq_rep_release;
               end else begin
                  next_cur.shift = receiving ? 8'hff : cur.shift_data;
                  if (cur.addr_phase) begin
                     next_cur.is_read = cur.shift_data[0];
                  end
                  next_cur.bit_idx = 4'h0;
                  next_cur.seq = two_wire_pkg::seq_bit_low;
               end
            end
         end
         two_wire_pkg::seq_bit_low: begin
            if (tick) begin
               next_cur.drive.sda_oe = drive_low(cur.bit_idx, cur.shift, receiving,
                                                 cur.ctrl.acknowledge_enable);
               next_cur.seq = two_wire_pkg::seq_bit_rise;
            end
         end
         two_wire_pkg::seq_bit_rise: begin
            // data settles a quarter before scl is let go, so no false start or stop
            // waiting for scl high honours clock stretching by the slave
            if (tick && cur.drive.scl_oe) begin
               next_cur.drive.scl_oe = 1'b0;
            end else if (tick && scl_clean) begin
               next_cur.sampled = sda_clean;
               lost = !receiving && (cur.bit_idx < 4'h8) && !cur.drive.sda_oe && !sda_clean;
               if (lost) begin
                  next_cur.drive.scl_oe = 1'b0;
                  next_cur.drive.sda_oe = 1'b0;
                  next_cur.own_bus = 1'b0;
                  next_cur.status_code = `ST_ARB_LOST;
                  hw_set = 1'b1;
                  next_cur.seq = two_wire_pkg::seq_hold;
               end else begin
                  next_cur.seq = two_wire_pkg::seq_bit_fall;
               end
            end
         end
         two_wire_pkg::seq_bit_fall: begin
            if (tick) begin
               next_cur.drive.scl_oe = 1'b1;
               next_cur.shift = {cur.shift[6:0], cur.sampled};
               if ((cur.bit_idx == 4'h7) && receiving) begin
                  next_cur.shift_data = {cur.shift[6:0], cur.sampled};
               end
               if (cur.bit_idx == 4'h8) begin
                  next_cur.status_code = status_for(cur.addr_phase, cur.is_read,
                                                    cur.sampled);
                  next_cur.addr_phase = 1'b0;
                  hw_set = 1'b1;
                  next_cur.seq = two_wire_pkg::seq_hold;
               end else begin
                  next_cur.bit_idx = cur.bit_idx + 4'h1;
                  next_cur.seq = two_wire_pkg::seq_bit_low;
               end
            end
         end
         two_wire_pkg::seq_stop_low: begin
            if (tick) begin
               next_cur.drive.sda_oe = 1'b1;
               next_cur.seq = two_wire_pkg::seq_stop_rise;
            end
         end
         two_wire_pkg::seq_stop_rise: begin
            if (tick) begin
               next_cur.drive.scl_oe = 1'b0;
               next_cur.seq = two_wire_pkg::seq_stop_end;
            end
         end
         two_wire_pkg::seq_stop_end: begin
            if (tick && scl_clean) begin
               next_cur.drive.sda_oe = 1'b0;
               next_cur.ctrl.stop_request = 1'b0;
               next_cur.own_bus = 1'b0;
               next_cur.status_code = `ST_NO_INFO;
               next_cur.seq = cur.ctrl.start_request ? two_wire_pkg::seq_wait_free
                                                     : two_wire_pkg::seq_idle;
            end
         end
         two_wire_pkg::seq_rep_release: begin
            if (tick) begin
               next_cur.drive.sda_oe = 1'b0;
               next_cur.seq = two_wire_pkg::seq_rep_rise;
            end
         end
         two_wire_pkg::seq_rep_rise: begin
            if (tick) begin
               next_cur.drive.scl_oe = 1'b0;
               next_cur.seq = two_wire_pkg::seq_wait_free;
            end
         end
         default: begin
            next_cur.seq = two_wire_pkg::seq_idle;
         end
      endcase

      // set wins over a clear in the same cycle
      next_cur.ctrl.flag = (cur.ctrl.flag && !flag_clear) || hw_set;

      // disabling drops the bus at once, mid-byte or not
      if (!cur.ctrl.enable) begin
         next_cur.seq = two_wire_pkg::seq_idle;
         next_cur.drive = '0;
         next_cur.own_bus = 1'b0;
         next_cur.busy = 1'b0;
         next_cur.addr_phase = 1'b0;
         next_cur.ctrl.flag = cur.ctrl.flag && !flag_clear;
      end

      // slave roles are not built; the port never answers an address
      next_cur.drive_level = 1'b0;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cur <= '0;
         cur.seq <= two_wire_pkg::seq_idle;
         cur.shift_data <= `DATA_RESET;
         cur.status_code <= `ST_NO_INFO;
         cur.prescale <= `PRESCALE_RESET;
         cur.scl_prev <= 1'b1;
         cur.sda_prev <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata_out = cur.rdata;
   assign scl_out = cur.drive_level;
   assign sda_out = cur.drive_level;
   assign scl_oe_out = cur.drive.scl_oe;
   assign sda_oe_out = cur.drive.sda_oe;

endmodule // two_wire_master_transmitter

`default_nettype wire

// *** sim/two_wire_sva.sv ***
// checker of pin levels, start timing and register reads of the two-wire port
`timescale 1ns/1ps
`default_nettype none
module two_wire_sva (
   input wire logic                   clk_in,
   input wire logic                   rst_n_in,
   input wire two_wire_pkg::bus_req_t reg_req_in,
   input wire logic [7:0]             rdata_out,
   input wire logic                   scl_in,
   input wire logic                   scl_out,
   input wire logic                   scl_oe_out,
   input wire logic                   sda_in,
   input wire logic                   sda_out,
   input wire logic                   sda_oe_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // ----
   // sequences
   // ----
   sequence rd_at(logic [1:0] a);
      reg_req_in.read && reg_req_in.addr == a;
   endsequence
   // data line pulled while the clock line stays released
   sequence start_edge;
      $rose(sda_oe_out) && $stable(scl_oe_out) && !scl_oe_out;
   endsequence
   sequence turn_off;
      reg_req_in.write && reg_req_in.addr == 2'h0 && !reg_req_in.wdata[2];
   endsequence
   // ----
   // assertions
   // ----
   a_pins_low: assert property (!scl_out && !sda_out)
      else $error("pin level not low");
   a_rdata_gap: assert property (!$past(reg_req_in.read) |-> rdata_out == 8'h00)
      else $error("read data outside slot");
   a_ctrl_spare: assert property (rd_at(2'h0) |=> !rdata_out[1])
      else $error("spare control bit set");
   a_unmapped_zero: assert property (rd_at(2'h3) |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_status_low: assert property (rd_at(2'h2) |=> !rdata_out[2])
      else $error("status bit two set");
   a_off_release: assert property (turn_off |-> ##2 (!scl_oe_out && !sda_oe_out) [*4])
      else $error("lines driven while off");
   a_start_free: assert property (start_edge |-> $past(scl_in, 2) && $past(sda_in, 2))
      else $error("start on busy bus");
   a_start_hold: assert property (start_edge |-> ##[240:260] $rose(scl_oe_out))
      else $error("clock not held after start");
endmodule // two_wire_sva
bind two_wire_master_transmitter two_wire_sva u_two_wire_sva (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .reg_req_in(reg_req_in), .rdata_out(rdata_out), .scl_in(scl_in), .scl_out(scl_out),
   .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
`default_nettype wire

// *** sim/slave_rx_model.sv ***
// slave receiver on the two-wire bus, sampled by the link clock
`timescale 1ns/1ps
`default_nettype none
module slave_rx_model (
   input  wire logic       lclk_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       ack_in,
   output var  logic       pull_out,
   output var  logic [7:0] byte_out
);
   logic       scl_q = 1'b1;
   logic       sda_q = 1'b1;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   initial pull_out = 1'b0;
   initial byte_out = 8'h00;
   always @(posedge lclk_in) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (scl_q && scl_in && sda_q && !sda_in) begin
         cnt <= 4'h0;
      end else if (!scl_q && scl_in && cnt < 4'h9) begin
         sh  <= (cnt < 4'h8) ? {sh[6:0], sda_in} : sh;
         cnt <= cnt + 4'h1;
      end else if (scl_q && !scl_in && cnt == 4'h8) begin
         pull_out <= ack_in;
         byte_out <= sh;
      end else if (scl_q && !scl_in && cnt == 4'h9) begin
         pull_out <= 1'b0; // released, so the pull-up lifts the line
         cnt      <= 4'h0;
      end
   end
endmodule // slave_rx_model
`default_nettype wire

// *** sim/two_wire_master_transmitter_tb.sv ***
// self-checking bench of the two-wire port master sequencer
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_transmitter_tb;
   logic                   clk_in = 1'b0;
   logic                   lclk = 1'b0;
   logic                   rst_n_in = 1'b0;
   logic                   hog = 1'b0;
   logic                   ack = 1'b1;
   two_wire_pkg::bus_req_t req = '0;
   logic [7:0]             rdata_out, got, sent, v;
   logic                   scl_out, scl_oe_out, sda_out, sda_oe_out, pull;
   int                     n_fail = 0;
   int                     tests_run = 0;
   int                     cycles = 0;
   wire logic              scl = !scl_oe_out;
   wire logic              sda = !(sda_oe_out || pull || hog);
   always #5 clk_in = ~clk_in;
   always #62.5 lclk = ~lclk;
   two_wire_master_transmitter u_two_wire_master_transmitter (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .reg_req_in(req), .rdata_out(rdata_out), .scl_in(scl), .scl_out(scl_out), .scl_oe_out(scl_oe_out),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
   slave_rx_model u_slave_rx_model (.lclk_in(lclk), .scl_in(scl), .sda_in(sda), .ack_in(ack),
      .pull_out(pull), .byte_out(got));
   // ----
   // tasks
   // ----
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_in) req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_in) req.write <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge clk_in) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_in) req.read <= 1'b0;
      @(posedge clk_in) v = rdata_out;
   endtask
   task automatic status(input logic [7:0] code);
      rd(2'h0);
      for (int i = 0; i < 9999 && !v[7]; i++) rd(2'h0);
      rd(2'h2);
      check(v & 8'hf8, code);
   endtask
   task automatic send(input logic [7:0] b, input logic a, input logic [7:0] code);
      ack <= a;
      wr(2'h1, b);
      wr(2'h0, 8'h84);
      status(code);
      check(got, b);
   endtask
   task automatic stop_bus();
      wr(2'h0, 8'h94);
      rd(2'h0);
      for (int i = 0; i < 999 && v[4]; i++) rd(2'h0);
      check(v, 8'h04);
      rd(2'h2);
      check(v & 8'hf8, 8'hf8);
      check({7'h00, sda}, 8'h01);
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ----
   // hang guard, well above the expected run of some 55000 cycles
   // ----
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         n_fail++;
         complete_run();
      end
   end
   // ----
   // main sequence
   // ----
   initial begin
      void'($urandom(32'hd751));
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(2'h0);
      check(v, 8'h00);
      wr(2'h2, 8'h03);
      rd(2'h2);
      check(v, 8'hfb);
      wr(2'h3, 8'h5a);
      rd(2'h3);
      check(v, 8'h00);
      wr(2'h1, 8'h3c);
      rd(2'h0);
      check(v, 8'h08);
      rd(2'h1);
      check(v, 8'hff);
      hog <= 1'b1;
      wr(2'h0, 8'ha4);
      repeat (2000) @(posedge clk_in);
      rd(2'h0);
      check(v, 8'h2c);
      hog <= 1'b0;
      status(8'h08);
      wr(2'h0, 8'h04);
      repeat (1000) @(posedge clk_in);
      rd(2'h0);
      check(v, 8'h8c);
      check({7'h00, scl}, 8'h00);
      sent = {7'($urandom), 1'b0};
      send(sent, 1'b1, 8'h18);
      rd(2'h0);
      check(v, 8'h84);
      send(8'h01, 1'b1, 8'h28);
      send(8'($urandom), 1'b0, 8'h30);
      stop_bus();
      wr(2'h0, 8'ha4);
      status(8'h08);
      send({7'($urandom), 1'b0}, 1'b0, 8'h20);
      wr(2'h0, 8'ha4);
      status(8'h10);
      send({7'($urandom), 1'b0}, 1'b1, 8'h18);
      wr(2'h1, 8'h55);
      wr(2'h0, 8'h84);
      repeat (3000) @(posedge clk_in);
      wr(2'h0, 8'h00);
      repeat (20) @(posedge clk_in);
      check({6'h00, scl, sda}, 8'h03);
      rd(2'h0);
      check(v, 8'h00);
      complete_run();
   end
endmodule // two_wire_master_transmitter_tb
`default_nettype wire
